// ==== rtl/dio_pkg.sv ====
// package for the memory-mapped digital port block
package dio_pkg;

    // data memory addresses of the port block
    localparam logic [11:0] DIO_PORT0_ADDR  = 12'hff0;
    localparam logic [11:0] DIO_PORT8_ADDR  = 12'hff8;
    localparam logic [11:0] DIO_DIR_A_ADDR  = 12'hfe8;
    localparam logic [11:0] DIO_DIR_B_ADDR  = 12'hfea;
    localparam logic [11:0] DIO_DIR_C_ADDR  = 12'hfec;
    localparam logic [3:0]  DIO_IO_BANK     = 4'hf;
    localparam logic [7:0]  DIO_DIR_RESET   = 8'h00;
    localparam logic [3:0]  DIO_LATCH_RESET = 4'h0;
    localparam int          DIO_NPORTS      = 9;
    localparam int          DIO_FILT_CYCLES = 4;

    typedef enum logic [2:0]
    {
        DIO_OP_NONE  = 3'b000,
        DIO_OP_READ  = 3'b001,
        DIO_OP_WRITE = 3'b010,
        DIO_OP_XCH   = 3'b011,
        DIO_OP_INC   = 3'b100,
        DIO_OP_BSET  = 3'b101,
        DIO_OP_BCLR  = 3'b110,
        DIO_OP_BTCLR = 3'b111
    } dio_op_t;

    // one cpu data memory request
    typedef struct packed
    {
        dio_op_t     op;
        logic        wide;
        logic        bit_mode;
        logic        indirect;
        logic [11:0] addr;
        logic [1:0]  bit_num;
        logic [1:0]  l_low;
        logic [7:0]  wdata;
    } dio_req_t;

endpackage : dio_pkg

// ==== rtl/dio_ports.sv ====
// memory-mapped digital i/o ports 0 to 8 with direction groups
// Contract
// - direction bit 0 means input with buffer off, 1 means output driven.
// - group a holds one direction bit per pin of ports 3 and 6.
// - group b sets ports 2, 4, 5, 7 with one bit per port.
// - group c sets both port 8 pins with one bit.
// - entering output mode drives current latch at once; load latch first.
// - direction groups are written as whole bytes by byte writes.
// - reset clears all direction bits, every port starts as input.
// - reset clears output latches of ports 2 to 8.
// - ports 0 and 1 pins readable at any time.
// - ports 4-5 and 6-7 pair into one byte for wide access.
// - reads return pins in input mode, latch in output mode.
// - nibble or byte writes update latch; pins show it only when output.
// - exchange in input mode returns pins, stores cpu value in latch.
// - increment in input mode stores pin value plus one into latch.
// - bit ops in input mode rewrite addressed bit; others may change.
// - exchange in output mode returns latch and loads cpu value.
// - increment in output mode adds one to latch and drives it.
// - bit write in output mode changes only the addressed latch bit.
// - bit accesses reach ports regardless of bank enable and select.
// - indirect bit access takes low address and bit number from l bits.
// - port1_pin0 feeds the vectored interrupt input through a noise filter.
// - all port registers sit in data memory space.
`timescale 1ns/1ps
`default_nettype none

module dio_ports
    import dio_pkg::*;
#(
    parameter int FILT_CYCLES = DIO_FILT_CYCLES
)
(
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        reset_in,
    input  wire logic        clk_en_in,
    // cpu data memory access
    input  wire dio_req_t    req_in,
    input  wire logic        bank_enable_flag_in,
    input  wire logic [3:0]  bank_select_value_in,
    output logic             hit_out,
    output logic [7:0]       rdata_out,
    output logic             bit_out,
    // pins
    input  wire logic [35:0] pin_in,
    output logic      [35:0] pin_out,
    output logic      [35:0] pin_oe_n_out,
    // filtered vectored interrupt input
    output logic             ext_irq_level_out
);

    // latch and direction state
    logic [3:0]  latch_q [DIO_NPORTS];
    logic [3:0]  latch_d [DIO_NPORTS];
    logic [7:0]  dir_a_q;
    logic [7:0]  dir_b_q;
    logic [7:0]  dir_c_q;
    logic [7:0]  dir_a_d;
    logic [7:0]  dir_b_d;
    logic [7:0]  dir_c_d;

    // per-port views
    logic [3:0]  dir_p   [DIO_NPORTS];
    logic [3:0]  view    [DIO_NPORTS];
    logic [3:0]  pins    [DIO_NPORTS];

    // request decode
    logic [11:0] eff_addr;
    logic [3:0]  port_idx;
    logic [1:0]  bsel;
    logic        in_ports;
    logic        bank_ok;
    logic        port_hit;
    logic        dir_hit;
    logic [3:0]  nib_r;
    logic [3:0]  nib_hi_r;
    logic        pair_ok;
    logic        dir_wr;
    logic        latch_wr;

    // answer to the cpu
    logic [7:0]  rdata_d;
    logic        bit_d;
    logic        hit_d;

    // interrupt pin filter
    logic [2:0]  filt_cnt_q;
    logic [2:0]  filt_cnt_d;
    logic        filt_q;
    logic        filt_d;

    // per-pin direction from the three groups
    always_comb
    begin
        for (int p = 0; p < DIO_NPORTS; p++)
        begin
            dir_p[p] = 4'h0;
        end
        dir_p[3] = dir_a_q[3:0];
        dir_p[6] = dir_a_q[7:4];
        dir_p[2] = {4{dir_b_q[2]}};
        dir_p[4] = {4{dir_b_q[4]}};
        dir_p[5] = {4{dir_b_q[5]}};
        dir_p[7] = {4{dir_b_q[7]}};
        // port 8 has only two pins; the upper two never drive
        dir_p[8] = {2'b00, {2{dir_c_q[0]}}};
    end

    // pin drive: latch always on pin_out, enable from direction
    always_comb
    begin
        for (int p = 0; p < DIO_NPORTS; p++)
        begin
            for (int b = 0; b < 4; b++)
            begin
                pin_out[p*4+b]      = latch_q[p][b];
                pin_oe_n_out[p*4+b] = ~dir_p[p][b];
            end
        end
    end

    // read view per bit; ports 0 and 1 have no direction, so always pins
    always_comb
    begin
        for (int p = 0; p < DIO_NPORTS; p++)
        begin
            pins[p] = pin_in[p*4 +: 4];
            for (int b = 0; b < 4; b++)
            begin
                view[p][b] = dir_p[p][b] ? latch_q[p][b] : pins[p][b];
            end
        end
    end

    // address decode; bit accesses ignore the bank settings
    always_comb
    begin
        eff_addr = req_in.addr;
        bsel     = req_in.bit_num;
        // indirect bit access replaces the low address bits as well
        if (req_in.bit_mode && req_in.indirect)
        begin
            eff_addr = {req_in.addr[11:2], req_in.l_low};
            bsel     = req_in.l_low;
        end
        in_ports = (eff_addr >= DIO_PORT0_ADDR) && (eff_addr <= DIO_PORT8_ADDR);
        port_idx = eff_addr[3:0];
        bank_ok  = req_in.bit_mode || !bank_enable_flag_in
                   || (bank_select_value_in == DIO_IO_BANK);
        pair_ok  = !req_in.wide || (port_idx == 4'd4) || (port_idx == 4'd6);
        port_hit = (req_in.op != DIO_OP_NONE) && in_ports && bank_ok && pair_ok;
        dir_hit  = (req_in.op != DIO_OP_NONE) && !req_in.bit_mode && req_in.wide && bank_ok
                   && ((req_in.addr == DIO_DIR_A_ADDR) || (req_in.addr == DIO_DIR_B_ADDR)
                       || (req_in.addr == DIO_DIR_C_ADDR));
        dir_wr   = dir_hit && (req_in.op == DIO_OP_WRITE);
        latch_wr = port_hit && (port_idx >= 4'd2);
        hit_d    = port_hit || dir_hit;
    end

    // operand nibbles; the upper one only matters for paired access
    always_comb
    begin
        nib_r    = in_ports ? view[port_idx] : 4'h0;
        nib_hi_r = (in_ports && port_idx < 4'd8) ? view[port_idx + 4'd1] : 4'h0;
    end

    // read data and bit result
    always_comb
    begin
        rdata_d = 8'h00;
        bit_d   = 1'b0;
        if (port_hit)
        begin
            rdata_d = req_in.wide ? {nib_hi_r, nib_r} : {4'h0, nib_r};
            bit_d   = nib_r[bsel];
        end
        else if (dir_hit)
        begin
            // direction groups read back exactly as written
            unique case (req_in.addr)
                DIO_DIR_A_ADDR: rdata_d = dir_a_q;
                DIO_DIR_B_ADDR: rdata_d = dir_b_q;
                default:        rdata_d = dir_c_q;
            endcase
        end
    end

    // answers from flip-flops one cycle after the request
    // registered so the cpu sees a word that cannot glitch with the pins
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            hit_out   <= 1'b0;
            rdata_out <= 8'h00;
            bit_out   <= 1'b0;
        end
        else if (clk_en_in)
        begin
            hit_out   <= hit_d;
            rdata_out <= rdata_d;
            bit_out   <= bit_d;
        end
    end

    // direction groups, byte-wide writes only
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            dir_a_q <= DIO_DIR_RESET;
            dir_b_q <= DIO_DIR_RESET;
            dir_c_q <= DIO_DIR_RESET;
        end
        else if (clk_en_in)
        begin
            dir_a_q <= dir_a_d;
            dir_b_q <= dir_b_d;
            dir_c_q <= dir_c_d;
        end
    end

    // next direction groups; nibble writes cannot reach them
    always_comb
    begin
        dir_a_d = dir_a_q;
        dir_b_d = dir_b_q;
        dir_c_d = dir_c_q;
        if (dir_wr)
        begin
            unique case (req_in.addr)
                DIO_DIR_A_ADDR: dir_a_d = req_in.wdata;
                DIO_DIR_B_ADDR: dir_b_d = req_in.wdata;
                default:        dir_c_d = req_in.wdata;
            endcase
        end
    end

    // output latches; ports 0 and 1 are input only, their latches stay idle
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            for (int p = 0; p < DIO_NPORTS; p++)
            begin
                latch_q[p] <= DIO_LATCH_RESET;
            end
        end
        else if (clk_en_in)
        begin
            for (int p = 0; p < DIO_NPORTS; p++)
            begin
                latch_q[p] <= latch_d[p];
            end
        end
    end

    // next latch values; the array holds unless this cycle writes it
    always_comb
    begin
        for (int p = 0; p < DIO_NPORTS; p++)
        begin
            latch_d[p] = latch_q[p];
        end
        if (latch_wr)
        begin
            unique case (req_in.op)
                DIO_OP_WRITE, DIO_OP_XCH:
                begin
                    latch_d[port_idx] = req_in.wdata[3:0];
                    // paired access puts the high nibble in the odd port
                    if (req_in.wide)
                    begin
                        latch_d[port_idx + 4'd1] = req_in.wdata[7:4];
                    end
                end
                DIO_OP_INC:
                begin
                    // nibble-wide increment; the carry out is dropped
                    latch_d[port_idx] = nib_r + 4'h1;
                end
                // input mode: other bits reload from pins, a permitted undefined
                DIO_OP_BSET, DIO_OP_BCLR, DIO_OP_BTCLR:
                begin
                    for (int b = 0; b < 4; b++)
                    begin
                        if (b == int'(bsel))
                        begin
                            latch_d[port_idx][b] = (req_in.op == DIO_OP_BSET);
                        end
                        else if (!dir_p[port_idx][b])
                        begin
                            latch_d[port_idx][b] = pins[port_idx][b];
                        end
                    end
                end
                default:
                begin
                end
            endcase
        end
    end

    // noise filter: level must hold for FILT_CYCLES before passing;
    // the 3-bit count limits FILT_CYCLES to 8
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            filt_cnt_q <= 3'd0;
            filt_q     <= 1'b0;
        end
        else if (clk_en_in)
        begin
            filt_cnt_q <= filt_cnt_d;
            filt_q     <= filt_d;
        end
    end

    // a glitch shorter than the window restarts the count, never flips the level
    always_comb
    begin
        filt_cnt_d = filt_cnt_q + 3'd1;
        filt_d     = filt_q;
        if (pin_in[4] == filt_q)
        begin
            filt_cnt_d = 3'd0;
        end
        else if (filt_cnt_q == 3'(FILT_CYCLES - 1))
        begin
            filt_d     = pin_in[4];
            filt_cnt_d = 3'd0;
        end
    end

    assign ext_irq_level_out = filt_q;

endmodule : dio_ports

`default_nettype wire

// ==== dv/dio_ports_sva.sv ====
// assertions on the digital port block
`timescale 1ns/1ps
`default_nettype none
module dio_ports_sva
    import dio_pkg::*;
#(
    parameter int FILT_CYCLES = DIO_FILT_CYCLES
)
(
    // clock and reset
    input wire logic        clk_in,
    input wire logic        reset_in,
    input wire logic        clk_en_in,
    // cpu side
    input wire dio_req_t    req_in,
    input wire logic        bank_enable_flag_in,
    input wire logic [3:0]  bank_select_value_in,
    input wire logic        hit_out,
    input wire logic [7:0]  rdata_out,
    input wire logic        bit_out,
    // pins
    input wire logic [35:0] pin_in,
    input wire logic [35:0] pin_out,
    input wire logic [35:0] pin_oe_n_out,
    input wire logic        ext_irq_level_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    // bank state gates only nibble and byte access
    wire        bank_ok = !bank_enable_flag_in || bank_select_value_in == DIO_IO_BANK;
    wire        dir_wr  = clk_en_in && req_in.op == DIO_OP_WRITE && req_in.wide && bank_ok;
    logic [7:0] wd_q;
    always_ff @(posedge clk_in)
        wd_q <= req_in.wdata;
    chk_oe_reset: assert property ($fell(reset_in) |-> &pin_oe_n_out)
        else $error("pin driven after reset");
    chk_latch_reset: assert property ($fell(reset_in) |-> pin_out[33:8] == '0)
        else $error("latch not cleared by reset");
    chk_dir_a: assert property (dir_wr && req_in.addr == DIO_DIR_A_ADDR
        |=> pin_oe_n_out[27:24] == ~wd_q[7:4] && pin_oe_n_out[15:12] == ~wd_q[3:0])
        else $error("group a mapping wrong");
    chk_dir_b: assert property (dir_wr && req_in.addr == DIO_DIR_B_ADDR
        |=> pin_oe_n_out[11:8] == {4{~wd_q[2]}} && pin_oe_n_out[23:16] == {{4{~wd_q[5]}}, {4{~wd_q[4]}}})
        else $error("group b mapping wrong");
    chk_dir_c: assert property (dir_wr && req_in.addr == DIO_DIR_C_ADDR
        |=> pin_oe_n_out[33:32] == {2{~wd_q[0]}})
        else $error("group c mapping wrong");
    chk_read_view: assert property (clk_en_in && bank_ok && req_in.op == DIO_OP_READ && !req_in.wide
        && !req_in.bit_mode && req_in.addr == 12'hff2
        |=> rdata_out[3:0] == ($past(pin_oe_n_out[8]) ? $past(pin_in[11:8]) : $past(pin_out[11:8])))
        else $error("read shows wrong source");
    chk_bank_refuse: assert property (clk_en_in && req_in.op != DIO_OP_NONE && !req_in.bit_mode && !bank_ok
        |=> !hit_out)
        else $error("access taken in wrong bank");
    chk_irq_filter: assert property ((clk_en_in && pin_in[4]) [*8] |=> ext_irq_level_out)
        else $error("filtered input missed steady level");
endmodule : dio_ports_sva
bind dio_ports dio_ports_sva #(.FILT_CYCLES(FILT_CYCLES)) u_sva (.clk_in(clk_in), .reset_in(reset_in),
    .clk_en_in(clk_en_in), .req_in(req_in), .bank_enable_flag_in(bank_enable_flag_in),
    .bank_select_value_in(bank_select_value_in), .hit_out(hit_out), .rdata_out(rdata_out), .bit_out(bit_out),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n_out(pin_oe_n_out), .ext_irq_level_out(ext_irq_level_out));
`default_nettype wire

// ==== dv/dio_pin_model.sv ====
// board-side pin model
`timescale 1ns/1ps
`default_nettype none
module dio_pin_model
(
    // board and device sides
    input  wire logic [35:0] board_in,
    input  wire logic [35:0] drive_in,
    input  wire logic [35:0] oe_n_in,
    output logic      [35:0] level_out
);
    // released pins follow the board, never the last latch value
    assign level_out = (~oe_n_in & drive_in) | (oe_n_in & board_in);
endmodule : dio_pin_model
`default_nettype wire

// ==== dv/dio_ports_tb_top.sv ====
// self-checking bench for the digital port block
`timescale 1ns/1ps
`default_nettype none
module dio_ports_tb_top
    import dio_pkg::*;
;
    logic        clk_in, reset_in, clk_en_in, bank_en, hit, bit_o, irq;
    logic [3:0]  bank_sel;
    logic [7:0]  rdata;
    logic [35:0] board, pins, drv, oe_n;
    dio_req_t    req;
    int          errors, n_checks;
    dio_ports #(.FILT_CYCLES(4)) dut (.clk_in(clk_in), .reset_in(reset_in), .clk_en_in(clk_en_in),
        .req_in(req), .bank_enable_flag_in(bank_en), .bank_select_value_in(bank_sel), .hit_out(hit),
        .rdata_out(rdata), .bit_out(bit_o), .pin_in(pins), .pin_out(drv), .pin_oe_n_out(oe_n),
        .ext_irq_level_out(irq));
    dio_pin_model pm (.board_in(board), .drive_in(drv), .oe_n_in(oe_n), .level_out(pins));
    task automatic chk(input logic [35:0] s, input logic [35:0] e, input string n);
        n_checks++;
        if (s !== e)
        begin
            errors++;
            $display("wrong value %s exp %h got %h", n, e, s);
        end
    endtask : chk
    // inputs move on the falling edge, answer sampled at the next falling edge
    task automatic go(input dio_op_t op, input logic [11:0] a, input logic [7:0] d = 8'h00,
        input logic w = 1'b0, input logic bm = 1'b0, input logic ind = 1'b0, input logic [1:0] bn = 2'h0);
        @(negedge clk_in);
        req = '{op, w, bm, ind, a, bn, bn, d};
        @(negedge clk_in);
        req.op = DIO_OP_NONE;
    endtask : go
    task automatic stop_test;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : stop_test
    initial
    begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end
    initial
    begin
        repeat (3000) @(posedge clk_in);
        errors++;
        stop_test;
    end
    initial
    begin
        errors = 0;
        n_checks = 0;
        reset_in = 1'b1;
        clk_en_in = 1'b1;
        bank_en = 1'b0;
        bank_sel = 4'h0;
        board = 36'h0_0000_0a90;
        req = '0;
        repeat (20) @(negedge clk_in);
        reset_in = 1'b0;
        chk(oe_n, 36'hf_ffff_ffff, "oe");
        chk(drv[33:8], 26'h0, "latch");
        for (int i = 0; i < 3; i++)
        begin
            go(DIO_OP_READ, DIO_DIR_A_ADDR + 12'(2 * i), 8'h00, 1'b1);
            chk(rdata, 8'h00, "dir");
        end
        board[15:12] = 4'ha;
        // latch loaded before the direction flips, so no glitch
        go(DIO_OP_WRITE, 12'hff3, 8'h05);
        chk({oe_n[15:12], drv[15:12]}, 8'hf5, "p3 wr");
        go(DIO_OP_READ, 12'hff3);
        chk(rdata[3:0], 4'ha, "p3 rd");
        go(DIO_OP_WRITE, DIO_DIR_A_ADDR, 8'h3c, 1'b1);
        chk({oe_n[27:24], oe_n[15:12], pins[15:12]}, 12'hc36, "dir a");
        go(DIO_OP_READ, 12'hff3);
        chk(rdata[3:0], 4'h6, "p3 mix");
        go(DIO_OP_WRITE, DIO_DIR_B_ADDR, 8'h30, 1'b1);
        chk({oe_n[31:16], oe_n[11:8]}, 20'hfc00f, "dir b");
        go(DIO_OP_WRITE, DIO_DIR_C_ADDR, 8'h01, 1'b1);
        chk(oe_n[33:32], 2'b00, "dir c");
        go(DIO_OP_WRITE, 12'hff4, 8'h3c, 1'b1);
        go(DIO_OP_READ, 12'hff4, 8'h00, 1'b1);
        chk({drv[23:16], rdata}, 16'h3c3c, "pair");
        go(DIO_OP_XCH, 12'hff4, 8'h07);
        chk({rdata[3:0], drv[19:16]}, 8'hc7, "xch out");
        go(DIO_OP_INC, 12'hff4);
        chk(drv[19:16], 4'h8, "inc out");
        go(DIO_OP_XCH, 12'hff2, 8'h04);
        chk({rdata[3:0], drv[11:8], oe_n[11:8]}, 12'ha4f, "xch in");
        go(DIO_OP_INC, 12'hff2);
        go(DIO_OP_READ, 12'hff2);
        chk(drv[11:8], 4'hb, "inc in");
        go(DIO_OP_BTCLR, 12'hff2, 8'h00, 1'b0, 1'b1, 1'b0, 2'h3);
        chk({bit_o, drv[11]}, 2'b10, "tclr");
        bank_en = 1'b1;
        go(DIO_OP_BCLR, 12'hff4, 8'h00, 1'b0, 1'b1, 1'b1, 2'h1);
        chk(drv[23:20], 4'h1, "bclr");
        go(DIO_OP_WRITE, 12'hff3, 8'h0f);
        chk({hit, drv[15:12]}, 5'h05, "bank0");
        bank_sel = 4'hf;
        go(DIO_OP_WRITE, 12'hff3, 8'h0f);
        chk({hit, drv[15:12]}, 5'h1f, "bank15");
        clk_en_in = 1'b0;
        go(DIO_OP_WRITE, 12'hff3, 8'h00);
        clk_en_in = 1'b1;
        chk(drv[15:12], 4'hf, "frozen");
        board[7:4] = 4'ha;
        repeat (10) @(negedge clk_in);
        chk(irq, 1'b0, "irq low");
        board[7:4] = 4'hb;
        repeat (2) @(negedge clk_in);
        chk(irq, 1'b0, "irq short");
        repeat (8) @(negedge clk_in);
        chk(irq, 1'b1, "irq");
        go(DIO_OP_READ, 12'hff1);
        chk(rdata[3:0], 4'hb, "p1");
        stop_test;
    end
endmodule : dio_ports_tb_top
`default_nettype wire
